// ### src/spm_ctrl_pkg.sv
// Package for the self-programming flash controller.
// Assumes one core clock domain; register reached on the core I/O port.
package spm_ctrl_pkg;
	// Control/status register location and layout
	localparam logic [5:0] CSR_IO_ADDR   = 6'h37;
	localparam logic [7:0] CSR_DATA_ADDR = 8'h57;
	localparam logic [7:0] CSR_RESET     = 8'h00;
	localparam int         BIT_IE        = 7;
	localparam int         BIT_BUSY      = 6;
	localparam int         BIT_RSV       = 5;
	localparam int         BIT_REEN      = 4;
	localparam int         BIT_LOCK      = 3;
	localparam int         BIT_PGWR      = 2;
	localparam int         BIT_PGER      = 1;
	localparam int         BIT_EN        = 0;

	// Accepted low five bit commands
	localparam logic [4:0] CMD_REEN  = 5'h11;
	localparam logic [4:0] CMD_LOCK  = 5'h09;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_FILL  = 5'h01;

	// Command windows in core clock cycles
	localparam logic [2:0] CMD_WINDOW_CYC = 3'h4;
	localparam logic [2:0] LPM_WINDOW_CYC = 3'h3;

	// Pointer fields
	localparam int PAGE_LSB   = 7;
	localparam int WORD_LSB   = 1;
	localparam int WORD_BITS  = 6;
	localparam int PAGE_BITS  = 8;
	localparam logic [7:0] PAGE_MASK_8K  = 8'h7f;
	localparam logic [7:0] PAGE_MASK_16K = 8'hff;

	// Variant geometry, word addresses
	localparam logic [14:0] FLASH_WORDS_8K  = 15'h2000;
	localparam logic [14:0] FLASH_WORDS_16K = 15'h4000;
	localparam logic [14:0] NO_CONCURRENT_READ_SECTION_START_8K   = 15'h1c00;
	localparam logic [14:0] NO_CONCURRENT_READ_SECTION_START_16K  = 15'h3800;
	localparam logic [14:0] BOOT_MIN_8K     = 15'h0080;
	localparam logic [14:0] BOOT_MIN_16K    = 15'h0100;

	typedef enum logic [1:0] {
		OP_IDLE  = 2'b00,
		OP_ARMED = 2'b01,
		OP_BUSY  = 2'b11
	} op_state_t;

	typedef struct packed {
		logic        erase;
		logic        write;
		logic        lock;
		logic [7:0]  page;
		logic [7:0]  lock_data;
	} flash_req_t;

	typedef struct packed {
		logic        valid;
		logic [5:0]  word;
		logic [15:0] data;
	} buf_fill_t;
endpackage : spm_ctrl_pkg

// ### src/self_program_flash_control.sv
// Self-programming control: register, command windows, buffer fill,
// page erase/write, lock write, lock/fuse read, section limits.
// Assumes the core pulses spm_strobe/lpm_strobe for one cycle per
// instruction and the flash array pulses flash_done when an op ends.
//
// Function
// - 8K variant: boot sizes 128..1024 words, reset address 0x1F80..0x1C00
// - 8K variant: concurrent section 0x0000-0x1BFF, other 0x1C00-0x1FFF
// - 8K variant: page from Z13:Z7, word from Z6:Z1, Z15:Z14 ignored
// - 16K variant: boot sizes 256..2048 words, reset address 0x3F00..0x3800
// - 16K variant: concurrent section 0x0000-0x37FF, other 0x3800-0x3FFF
// - 16K variant: page from Z14:Z7, word from Z6:Z1, Z15 ignored
// - Z0 zero for stores; selects byte for load reads
// - One eight-bit register at I/O 0x37, resets to zero
// - Ready interrupt requested while enable and global interrupt enable set and self-program bit clear
// - Erase/write into concurrent section sets busy flag, blocking it
// - Busy clears by re-enable after completion or by buffer load
// - Bit 5 always reads zero
// - Re-enable plus enable, then store within four cycles, unblocks section
// - Re-enable refused while erase or write is in progress
// - Writing re-enable bit aborts and discards the buffer load, except while an op is running
// - Lock-set command programs lock bits from low data register
// - Load within three cycles after lock-set returns lock or fuse bits
// - Page-write command writes buffer into pointer page
// - Page-erase command erases pointer page; bit clears on end or lapse
// - Enable alone fills buffer word; enable stays high during operation
// - Other low five bit values arm nothing; with bit 4 set they still discard the buffer load
// - Core stalls for whole operation on no-concurrent section page
`timescale 1ns/100ps
module self_program_flash_control #(
	parameter bit VARIANT_16K = 1'b0
) (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic [5:0]                io_addr,
	input  wire logic                      io_wr,
	input  wire logic [7:0]                io_wdata,
	output logic      [7:0]                io_rdata,
	input  wire logic                      global_irq_en,
	input  wire logic                      spm_strobe,
	input  wire logic                      lpm_strobe,
	input  wire logic [15:0]               z_ptr,
	input  wire logic [7:0]                data_lo,
	input  wire logic [7:0]                data_hi,
	input  wire logic [1:0]                boot_size_sel,
	input  wire logic [7:0]                lock_bits_in,
	input  wire logic [7:0]                fuse_bits_in,
	input  wire logic                      flash_done,
	output logic                           lpm_special,
	output logic      [7:0]                lpm_data,
	output spm_ctrl_pkg::buf_fill_t        buf_fill,
	output logic                           buf_discard,
	output spm_ctrl_pkg::flash_req_t       flash_req,
	output logic                           concurrent_section_busy,
	output logic                           core_stall,
	output logic                           ready_irq,
	output logic      [14:0]               boot_reset_addr,
	output logic      [14:0]               app_end_addr
);

	localparam logic [14:0] FLASH_WORDS = VARIANT_16K ? spm_ctrl_pkg::FLASH_WORDS_16K
		: spm_ctrl_pkg::FLASH_WORDS_8K;
	localparam logic [14:0] NO_CONCURRENT_READ_SECTION_START  = VARIANT_16K ? spm_ctrl_pkg::NO_CONCURRENT_READ_SECTION_START_16K
		: spm_ctrl_pkg::NO_CONCURRENT_READ_SECTION_START_8K;
	localparam logic [14:0] BOOT_MIN    = VARIANT_16K ? spm_ctrl_pkg::BOOT_MIN_16K
		: spm_ctrl_pkg::BOOT_MIN_8K;
	localparam logic [7:0]  PAGE_MASK   = VARIANT_16K ? spm_ctrl_pkg::PAGE_MASK_16K
		: spm_ctrl_pkg::PAGE_MASK_8K;

	spm_ctrl_pkg::op_state_t  state_reg;
	spm_ctrl_pkg::flash_req_t flash_req_reg;
	spm_ctrl_pkg::buf_fill_t  buf_fill_reg;
	logic [4:0]               cmd_reg;
	logic [2:0]               win_reg;
	logic                     ie_reg;
	logic                     busy_reg;
	logic                     stall_reg;
	logic                     discard_reg;
	logic                     irq_reg;
	logic [7:0]               rdata_reg;
	logic [7:0]               lpm_data_reg;
	logic [14:0]              boot_addr_reg;
	logic                     write_hit;
	logic                     legal_cmd;
	logic                     spm_go;
	logic                     long_op;
	logic                     lpm_window;
	logic [7:0]               page_sel;
	logic [5:0]               word_sel;
	logic                     in_concurrent;
	logic [7:0]               csr_value;
	logic [14:0]              boot_size;

	assign write_hit = io_wr && (io_addr == spm_ctrl_pkg::CSR_IO_ADDR);
	assign legal_cmd = (io_wdata[4:0] == spm_ctrl_pkg::CMD_REEN)
		|| (io_wdata[4:0] == spm_ctrl_pkg::CMD_LOCK)
		|| (io_wdata[4:0] == spm_ctrl_pkg::CMD_WRITE)
		|| (io_wdata[4:0] == spm_ctrl_pkg::CMD_ERASE)
		|| (io_wdata[4:0] == spm_ctrl_pkg::CMD_FILL);
	assign spm_go    = (state_reg == spm_ctrl_pkg::OP_ARMED) && spm_strobe;
	assign long_op   = (cmd_reg == spm_ctrl_pkg::CMD_ERASE)
		|| (cmd_reg == spm_ctrl_pkg::CMD_WRITE);

	// Upper pointer bits beyond the counter never reach the page field
	assign page_sel = z_ptr[spm_ctrl_pkg::PAGE_LSB +: spm_ctrl_pkg::PAGE_BITS]
		& PAGE_MASK;
	assign word_sel = z_ptr[spm_ctrl_pkg::WORD_LSB +: spm_ctrl_pkg::WORD_BITS];
	assign in_concurrent = {1'b0, page_sel, 6'h00} < NO_CONCURRENT_READ_SECTION_START;

	assign lpm_window = (state_reg == spm_ctrl_pkg::OP_ARMED)
		&& (cmd_reg == spm_ctrl_pkg::CMD_LOCK)
		&& (win_reg > (spm_ctrl_pkg::CMD_WINDOW_CYC - spm_ctrl_pkg::LPM_WINDOW_CYC));

	assign csr_value = {ie_reg, busy_reg, 1'b0, cmd_reg};

	// Smallest boot area at selection 11, doubling per step down
	assign boot_size = BOOT_MIN << (2'h3 - boot_size_sel);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ie_reg <= spm_ctrl_pkg::CSR_RESET[spm_ctrl_pkg::BIT_IE];
		end else if (write_hit) begin
			ie_reg <= io_wdata[spm_ctrl_pkg::BIT_IE];
		end
	end

	// Command sequencer; writes during a running op are ignored
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= spm_ctrl_pkg::OP_IDLE;
			cmd_reg   <= spm_ctrl_pkg::CSR_RESET[4:0];
			win_reg   <= 3'h0;
		end else begin
			unique case (state_reg)
				spm_ctrl_pkg::OP_IDLE: begin
					if (write_hit && legal_cmd) begin
						state_reg <= spm_ctrl_pkg::OP_ARMED;
						cmd_reg   <= io_wdata[4:0];
						win_reg   <= spm_ctrl_pkg::CMD_WINDOW_CYC;
					end
				end
				spm_ctrl_pkg::OP_ARMED: begin
					if (spm_go) begin
						if (long_op || cmd_reg == spm_ctrl_pkg::CMD_LOCK) begin
							state_reg <= spm_ctrl_pkg::OP_BUSY;
						end else begin
							state_reg <= spm_ctrl_pkg::OP_IDLE;
							cmd_reg   <= 5'h00;
						end
						win_reg <= 3'h0;
					end else if (write_hit && legal_cmd) begin
						cmd_reg <= io_wdata[4:0];
						win_reg <= spm_ctrl_pkg::CMD_WINDOW_CYC;
					end else if (win_reg == 3'h1) begin
						state_reg <= spm_ctrl_pkg::OP_IDLE;
						cmd_reg   <= 5'h00;
						win_reg   <= 3'h0;
					end else begin
						win_reg <= win_reg - 3'h1;
					end
				end
				spm_ctrl_pkg::OP_BUSY: begin
					if (flash_done) begin
						state_reg <= spm_ctrl_pkg::OP_IDLE;
						cmd_reg   <= 5'h00;
					end
				end
				default: begin
					state_reg <= spm_ctrl_pkg::OP_IDLE;
					cmd_reg   <= 5'h00;
					win_reg   <= 3'h0;
				end
			endcase
		end
	end

	// Set beats clear: a new concurrent op wins over a re-enable
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= spm_ctrl_pkg::CSR_RESET[spm_ctrl_pkg::BIT_BUSY];
		end else if (spm_go && long_op && in_concurrent) begin
			busy_reg <= 1'b1;
		end else if (spm_go && (cmd_reg == spm_ctrl_pkg::CMD_FILL
			|| cmd_reg == spm_ctrl_pkg::CMD_REEN)) begin
			busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stall_reg <= 1'b0;
		end else if (spm_go && long_op && !in_concurrent) begin
			stall_reg <= 1'b1;
		end else if (state_reg == spm_ctrl_pkg::OP_BUSY && flash_done) begin
			stall_reg <= 1'b0;
		end
	end

	// Refused during an op, so a running page write keeps its buffer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			discard_reg <= 1'b0;
		end else begin
			discard_reg <= write_hit && io_wdata[spm_ctrl_pkg::BIT_REEN]
				&& (state_reg != spm_ctrl_pkg::OP_BUSY);
		end
	end

	// Z0 is dropped for stores; word select drives only the buffer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			buf_fill_reg <= '0;
		end else begin
			buf_fill_reg.valid <= spm_go && (cmd_reg == spm_ctrl_pkg::CMD_FILL);
			buf_fill_reg.word  <= word_sel;
			buf_fill_reg.data  <= {data_hi, data_lo};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flash_req_reg <= '0;
		end else begin
			flash_req_reg.erase     <= spm_go && (cmd_reg == spm_ctrl_pkg::CMD_ERASE);
			flash_req_reg.write     <= spm_go && (cmd_reg == spm_ctrl_pkg::CMD_WRITE);
			flash_req_reg.lock      <= spm_go && (cmd_reg == spm_ctrl_pkg::CMD_LOCK);
			flash_req_reg.page      <= page_sel;
			flash_req_reg.lock_data <= data_lo;
		end
	end

	// Lock/fuse readback; normal loads are not intercepted
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lpm_data_reg <= 8'h00;
		end else if (lpm_strobe && lpm_window) begin
			lpm_data_reg <= z_ptr[0] ? fuse_bits_in : lock_bits_in;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= ie_reg && global_irq_en && !cmd_reg[spm_ctrl_pkg::BIT_EN];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= spm_ctrl_pkg::CSR_RESET;
		end else begin
			rdata_reg <= csr_value;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			boot_addr_reg <= 15'h0000;
		end else begin
			boot_addr_reg <= FLASH_WORDS - boot_size;
		end
	end

	assign io_rdata                = rdata_reg;
	assign lpm_special             = lpm_strobe && lpm_window;
	assign lpm_data                = lpm_data_reg;
	assign buf_fill                = buf_fill_reg;
	assign buf_discard             = discard_reg;
	assign flash_req               = flash_req_reg;
	assign concurrent_section_busy = busy_reg;
	assign core_stall              = stall_reg;
	assign ready_irq               = irq_reg;
	assign boot_reset_addr         = boot_addr_reg;
	assign app_end_addr            = boot_addr_reg - 15'h0001;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_arm;
		write_hit && legal_cmd && state_reg == spm_ctrl_pkg::OP_IDLE;
	endsequence

	sequence s_no_store4;
		(!spm_strobe && !write_hit) [*4];
	endsequence

	a_window_lapse: assert property (s_arm ##1 s_no_store4 |=> cmd_reg == 5'h00)
		else $error("command bits did not clear after window");

	// A store inside the window ends it legally, so only quiet windows are judged
	a_window_open: assert property (s_arm ##1 (!spm_strobe && !write_hit) [*3]
		|=> state_reg == spm_ctrl_pkg::OP_ARMED)
		else $error("command window shorter than four cycles");

	a_busy_set: assert property (spm_go && long_op && in_concurrent
		|=> concurrent_section_busy)
		else $error("busy flag not set for concurrent op");

	a_reserved_zero: assert property (##1 io_rdata[spm_ctrl_pkg::BIT_RSV] == 1'b0)
		else $error("reserved bit read as one");

	a_irq_level: assert property (ie_reg && global_irq_en && !cmd_reg[0]
		|=> ready_irq)
		else $error("ready interrupt not requested");

	a_stall_no_concurrent_read_section: assert property (spm_go && long_op && !in_concurrent
		|=> core_stall until (state_reg == spm_ctrl_pkg::OP_IDLE))
		else $error("core not stalled during op");

	a_refuse_busy: assert property (state_reg == spm_ctrl_pkg::OP_BUSY && !flash_done
		|=> state_reg == spm_ctrl_pkg::OP_BUSY && cmd_reg[0])
		else $error("op abandoned before completion");

	a_fill_word: assert property (spm_go && cmd_reg == spm_ctrl_pkg::CMD_FILL
		|=> buf_fill.valid && buf_fill.word == $past(z_ptr[6:1]))
		else $error("buffer fill word wrong");

	a_page_top: assert property (flash_req.erase || flash_req.write
		|-> VARIANT_16K || !flash_req.page[7])
		else $error("ignored pointer bit reached page");

	a_lock_data: assert property (spm_go && cmd_reg == spm_ctrl_pkg::CMD_LOCK
		|=> flash_req.lock && flash_req.lock_data == $past(data_lo))
		else $error("lock data not taken from low register");

	a_boot_addr: assert property (##1 boot_size_sel == 2'h3 && $stable(boot_size_sel)
		|=> boot_reset_addr == (VARIANT_16K ? 15'h3f00 : 15'h1f80))
		else $error("boot reset address wrong");

	a_discard_reen: assert property (write_hit && io_wdata[spm_ctrl_pkg::BIT_REEN]
		&& state_reg != spm_ctrl_pkg::OP_BUSY |=> buf_discard)
		else $error("buffer not discarded on re-enable write");

	a_fill_unbusy: assert property (spm_go && cmd_reg == spm_ctrl_pkg::CMD_FILL
		|=> !concurrent_section_busy)
		else $error("buffer load left section busy");

	a_stray_store: assert property (state_reg != spm_ctrl_pkg::OP_ARMED && spm_strobe
		|=> !flash_req.erase && !flash_req.write && !flash_req.lock
		&& !buf_fill.valid)
		else $error("store outside window took effect");

	a_lock_read: assert property (lpm_special
		|=> lpm_data == ($past(z_ptr[0]) ? $past(fuse_bits_in) : $past(lock_bits_in)))
		else $error("lock or fuse readback wrong");

endmodule : self_program_flash_control

// ### dv/flash_array_model.sv
// Flash array stand-in: answers each erase, write or lock request.
// Assumes requests arrive as one-cycle pulses on mclk.
`timescale 1ns/100ps
module flash_array_model (
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	input  wire logic                     slow,
	input  wire spm_ctrl_pkg::flash_req_t req,
	output logic                          done
);
	logic [5:0] cnt_reg;

	// Real array takes milliseconds; a short count keeps the run brief
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 6'h00;
			done    <= 1'b0;
		end else begin
			done <= (cnt_reg == 6'h01);
			if (req.erase | req.write | req.lock)
				cnt_reg <= slow ? 6'h14 : 6'h03;
			else if (cnt_reg != 6'h00)
				cnt_reg <= cnt_reg - 6'h01;
		end
	end
endmodule : flash_array_model

// ### dv/self_program_flash_control_tb.sv
// Bench for the self-programming control, both flash geometries.
// Assumes the core side is driven here at falling edges.
`timescale 1ns/100ps
module self_program_flash_control_tb;
	typedef struct packed {
		logic [1:0]  sel;
		logic [14:0] b8;
		logic [14:0] b16;
	} boot_row_t;
	logic mclk, rst_n, io_wr, global_irq_en, spm_strobe, lpm_strobe, flash_done, slow;
	logic [5:0]  io_addr;
	logic [7:0]  io_wdata, io_rdata, data_lo, data_hi, lock_bits_in, fuse_bits_in, lpm_data;
	logic [15:0] z_ptr;
	logic [1:0]  boot_size_sel;
	logic        lpm_special, buf_discard, concurrent_section_busy, core_stall, ready_irq;
	logic        busy16, stall16;
	logic [14:0] boot_reset_addr, app_end_addr, br16, ae16;
	spm_ctrl_pkg::buf_fill_t  buf_fill;
	spm_ctrl_pkg::flash_req_t flash_req, f16;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	boot_row_t rows [4] = '{'{2'h3, 15'h1f80, 15'h3f00}, '{2'h2, 15'h1f00, 15'h3e00},
		'{2'h1, 15'h1e00, 15'h3c00}, '{2'h0, 15'h1c00, 15'h3800}};

	self_program_flash_control #(.VARIANT_16K(1'b0)) self_program_flash_control_inst (
		.mclk, .rst_n, .io_addr, .io_wr, .io_wdata, .io_rdata, .global_irq_en,
		.spm_strobe, .lpm_strobe, .z_ptr, .data_lo, .data_hi, .boot_size_sel,
		.lock_bits_in, .fuse_bits_in, .flash_done, .lpm_special, .lpm_data, .buf_fill,
		.buf_discard, .flash_req, .concurrent_section_busy, .core_stall, .ready_irq,
		.boot_reset_addr, .app_end_addr);
	// Second geometry shares every input; only its boot, end, page and busy outputs are judged
	self_program_flash_control #(.VARIANT_16K(1'b1)) wide_inst (
		.mclk, .rst_n, .io_addr, .io_wr, .io_wdata, .io_rdata(), .global_irq_en,
		.spm_strobe, .lpm_strobe, .z_ptr, .data_lo, .data_hi, .boot_size_sel,
		.lock_bits_in, .fuse_bits_in, .flash_done, .lpm_special(), .lpm_data(),
		.buf_fill(), .buf_discard(), .flash_req(f16), .concurrent_section_busy(busy16),
		.core_stall(stall16), .ready_irq(), .boot_reset_addr(br16), .app_end_addr(ae16));
	flash_array_model flash_array_model_inst (
		.mclk(mclk), .rst_n(rst_n), .slow(slow), .req(flash_req), .done(flash_done));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		io_addr = a;
		io_wdata = v;
		io_wr = 1'b1;
		@(negedge mclk);
		io_wr = 1'b0;
	endtask : wr

	task automatic spm(input logic [15:0] z, input logic [7:0] lo, input logic [7:0] hi);
		z_ptr = z;
		data_lo = lo;
		data_hi = hi;
		spm_strobe = 1'b1;
		@(negedge mclk);
		spm_strobe = 1'b0;
	endtask : spm

	task automatic lpm(input logic [15:0] z, input logic exp);
		z_ptr = z;
		lpm_strobe = 1'b1;
		#20;
		chk("lpm_special", lpm_special, exp);
		@(negedge mclk);
		lpm_strobe = 1'b0;
	endtask : lpm

	task automatic wait_idle();
		n = 0;
		while (io_rdata[0] !== 1'b0 && n < 60) begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
	endtask : wait_idle

	task automatic final_report();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// Whole sequence needs about a hundred cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			final_report();
		end
	end

	initial begin
		{rst_n, io_wr, global_irq_en, spm_strobe, lpm_strobe, slow} = 6'h00;
		{io_wdata, data_lo, data_hi, z_ptr, boot_size_sel} = 42'h0;
		io_addr = spm_ctrl_pkg::CSR_IO_ADDR;
		lock_bits_in = 8'ha5;
		fuse_bits_in = 8'h3c;
		repeat (4) @(negedge mclk);
		chk("end_rst", app_end_addr, 16'h7fff);
		rst_n = 1'b1;
		@(negedge mclk);
		chk("csr_rst", io_rdata, 16'h0000);
		foreach (rows[i]) begin
			boot_size_sel = rows[i].sel;
			repeat (2) @(negedge mclk);
			chk("boot8", boot_reset_addr, rows[i].b8);
			chk("end8", app_end_addr, rows[i].b8 - 15'h1);
			chk("boot16", br16, rows[i].b16);
			chk("end16", ae16, rows[i].b16 - 15'h1);
		end
		wr(6'h36, 8'h80);
		repeat (2) @(negedge mclk);
		chk("other_addr", io_rdata, 16'h0000);
		global_irq_en = 1'b1;
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h80);
		@(negedge mclk);
		chk("irq_on", ready_irq, 16'h1);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h81);
		@(negedge mclk);
		chk("irq_armed", ready_irq, 16'h0);
		repeat (5) @(negedge mclk);
		chk("lapse_ie", io_rdata, 16'h0080);
		chk("irq_back", ready_irq, 16'h1);
		global_irq_en = 1'b0;
		repeat (2) @(negedge mclk);
		chk("irq_global", ready_irq, 16'h0);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h27);
		repeat (2) @(negedge mclk);
		chk("illegal", io_rdata, 16'h0000);
		// Erase of a concurrent page, slow array; stores keep Z0 low
		slow = 1'b1;
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h03);
		spm(16'h4800, 8'h00, 8'h00);
		chk("erase", flash_req.erase, 16'h1);
		chk("page8", flash_req.page, 16'h0010);
		chk("page16", f16.page, 16'h0090);
		@(negedge mclk);
		chk("busy8", concurrent_section_busy, 16'h1);
		chk("busy16", busy16, 16'h1);
		chk("no_stall", core_stall, 16'h0);
		repeat (4) @(negedge mclk);
		chk("en_held", io_rdata, 16'h0043);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h11);
		spm(16'h0000, 8'h00, 8'h00);
		wait_idle();
		chk("reen_refused", io_rdata, 16'h0040);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h11);
		chk("discard", buf_discard, 16'h1);
		spm(16'h0000, 8'h00, 8'h00);
		@(negedge mclk);
		chk("reen", concurrent_section_busy, 16'h0);
		// Page write into the other section for 8K, the concurrent one for 16K; word field held at zero
		slow = 1'b0;
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h05);
		spm(16'hb800, 8'hff, 8'hff);
		chk("write", flash_req.write, 16'h1);
		chk("wpage", flash_req.page, 16'h0070);
		@(negedge mclk);
		chk("stall", core_stall, 16'h1);
		chk("no_concurrent_read_section_busy", concurrent_section_busy, 16'h0);
		chk("w16_busy", busy16, 16'h1);
		wait_idle();
		chk("stall_end", core_stall, 16'h0);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h01);
		spm(16'hc00a, 8'h34, 8'h12);
		chk("fill", buf_fill.valid, 16'h1);
		chk("word", buf_fill.word, 16'h0005);
		chk("data", buf_fill.data, 16'h1234);
		@(negedge mclk);
		chk("fill_unbusy", busy16, 16'h0);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h03);
		repeat (5) @(negedge mclk);
		chk("lapse", io_rdata, 16'h0000);
		spm(16'h4800, 8'h00, 8'h00);
		chk("late_spm", flash_req.erase, 16'h0);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h09);
		lpm(16'h0000, 1'b1);
		chk("lock_rd", lpm_data, 16'h00a5);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h09);
		lpm(16'h0001, 1'b1);
		chk("fuse_rd", lpm_data, 16'h003c);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h09);
		repeat (3) @(negedge mclk);
		lpm(16'h0000, 1'b0);
		wr(spm_ctrl_pkg::CSR_IO_ADDR, 8'h09);
		spm(16'hffff & 16'hfffe, 8'he3, 8'h5a);
		chk("lock", flash_req.lock, 16'h1);
		chk("lock_data", flash_req.lock_data, 16'h00e3);
		wait_idle();
		chk("lock_end", io_rdata, 16'h0000);
		final_report();
	end
endmodule : self_program_flash_control_tb
